// >>> rtl/soc_pkg.sv
// soc_pkg: shared constants and types for the output/current command block
// assumes: 32-bit apb data, one aligned word per register
package soc_pkg;

    // setpoint word width (current and voltage codes)
    localparam int SOC_DW = 16;

    // register byte offsets
    localparam logic [7:0] SOC_OFS_OUT_CTRL = 8'h00; // output enable 0/1
    localparam logic [7:0] SOC_OFS_VSET = 8'h04; // voltage setpoint
    localparam logic [7:0] SOC_OFS_ISET = 8'h08; // current setpoint
    localparam logic [7:0] SOC_OFS_ISET_MAX = 8'h0c; // ro: max current
    localparam logic [7:0] SOC_OFS_ISET_MIN = 8'h10; // ro: min current
    localparam logic [7:0] SOC_OFS_ILIM = 8'h14; // current limit
    localparam logic [7:0] SOC_OFS_IPROT = 8'h18; // overcurrent level
    localparam logic [7:0] SOC_OFS_IPROT_MAX = 8'h1c; // ro: factory max
    localparam logic [7:0] SOC_OFS_IPROT_MIN = 8'h20; // ro: min level
    localparam logic [7:0] SOC_OFS_IRANGE = 8'h24; // 0 low, 1 high
    localparam logic [7:0] SOC_OFS_ITRIG = 8'h28; // pending trig value
    localparam logic [7:0] SOC_OFS_TRIG_CMD = 8'h2c; // wo: apply trig
    localparam logic [7:0] SOC_OFS_MODE = 8'h30; // 0 fixed, 1 list
    localparam logic [7:0] SOC_OFS_LIST_CMD = 8'h34; // wo: list setup
    localparam logic [7:0] SOC_OFS_ERR = 8'h38; // ro: error, read clears
    localparam logic [7:0] SOC_OFS_STATUS = 8'h3c; // breaker, w1 clears

    // field positions
    localparam int SOC_BIT_ERR_VALID = 16;
    localparam int SOC_BIT_STAT_TRIP = 0;

    // error codes as 16-bit two's complement
    localparam logic [15:0] SOC_ERR_RANGE = 16'hff22; // -222
    localparam logic [15:0] SOC_ERR_CMD = 16'hff9c; // -100

    // reset values and model figures
    localparam logic [SOC_DW-1:0] SOC_IMAX_DEF = 16'hffff;
    localparam logic [SOC_DW-1:0] SOC_IPROT_MAX_DEF = 16'hffff;
    localparam logic [SOC_DW-1:0] SOC_RANGE_DIV = 16'h000a; // low = max/10
    localparam logic [SOC_DW-1:0] SOC_ZERO = 16'h0000;

    // apb request carrier
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } soc_apb_req_s;

    // apb answer carrier
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } soc_apb_rsp_s;

    // list sequencer step carrier
    typedef struct packed {
        logic valid;
        logic done;
        logic [SOC_DW-1:0] vset;
        logic [SOC_DW-1:0] iset;
    } soc_step_s;

    // list run state
    typedef enum logic {
        SOC_FIXED,
        SOC_LIST
    } soc_mode_e;

    // complete block state
    typedef struct packed {
        soc_apb_rsp_s rsp;
        logic out_en;
        logic range_hi;
        soc_mode_e mode;
        logic [SOC_DW-1:0] prog_v;
        logic [SOC_DW-1:0] prog_i;
        logic [SOC_DW-1:0] pre_v;
        logic [SOC_DW-1:0] pre_i;
        logic [SOC_DW-1:0] ilim;
        logic [SOC_DW-1:0] iprot;
        logic [SOC_DW-1:0] itrig;
        logic [SOC_DW-1:0] dac_v;
        logic [SOC_DW-1:0] dac_i;
        logic err_valid;
        logic [15:0] err_code;
        logic trip;
    } soc_state_s;

endpackage : soc_pkg

// >>> rtl/soc_cmd.sv
// soc_cmd: output enable, current setpoint, limit, protection, range,
// triggered value and list mode command logic behind an apb slave
// assumes: mclk 50 MHz, srst synchronous active high, list sequencer
// and current monitor inputs synchronous to mclk
// registers are one aligned 32-bit word each; setpoints sit in the low
// 16 bits of the data word and the upper bits are ignored on write
// a transfer is answered in its second access cycle, three cycles in all
// the monitored current is compared with the protection level each cycle
// the list sequencer drives one step word and a done pulse per list
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module soc_cmd
    import soc_pkg::*;
#(
    parameter logic [SOC_DW-1:0] IMAX = SOC_IMAX_DEF,
    parameter logic [SOC_DW-1:0] IPROT_MAX = SOC_IPROT_MAX_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // apb slave
    input wire soc_apb_req_s apb_req,
    output soc_apb_rsp_s apb_rsp,
    // list sequencer
    input wire soc_step_s list_step,
    output logic list_run,
    // current monitor
    input wire logic [SOC_DW-1:0] i_meas,
    // supply outputs
    output logic out_en,
    output logic range_hi,
    output logic [SOC_DW-1:0] dac_v,
    output logic [SOC_DW-1:0] dac_i,
    output logic breaker_trip
);

    ////////////////////////////////////////////////////////////////////////
    // state
    // st_r holds every flop of the block, st_nxt its value for the next
    // edge; all outputs are fields of st_r
    soc_state_s st_r;
    soc_state_s st_nxt;

    // bus strobes and the setpoint field of the write word
    logic acc;
    logic wr;
    logic rd_done;
    logic [SOC_DW-1:0] wval;

    // model maximum for the selected scale
    logic [SOC_DW-1:0] imax_eff;

    // error posting for this cycle
    logic err_set;
    logic [15:0] err_new;
    logic err_clr;

    // read side: offset decoded and the word to return
    logic hit;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: access phase answered one cycle after it starts
    // a transfer acts only at the edge where pready is already high; an
    // access phase held longer by the master acts again every second edge
    assign acc = apb_req.psel & apb_req.penable;
    assign wr = acc & apb_req.pwrite & st_r.rsp.pready;
    assign rd_done = acc & ~apb_req.pwrite & st_r.rsp.pready;
    // setpoint value from the low half of the data word
    assign wval = apb_req.pwdata[SOC_DW-1:0];

    // effective model maximum for the selected scale
    // the low scale only changes the maximum query; the limit checks
    // compare against ilim and iprot in either scale
    assign imax_eff = st_r.range_hi ? IMAX
                                    : IMAX / SOC_RANGE_DIV;

    ////////////////////////////////////////////////////////////////////////
    // read mux
    // write-only commands read as zero; an unmapped offset returns zero
    // and raises pslverr together with pready
    always_comb begin
        // default: mapped offset, zero data
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (apb_req.paddr)
            SOC_OFS_OUT_CTRL: begin
                rdata[0] = st_r.out_en;
            end
            // setpoints read back the saved copy while the output
            // is off, never the zeroed dac words
            SOC_OFS_VSET: begin
                rdata[SOC_DW-1:0] = st_r.prog_v;
            end
            SOC_OFS_ISET: begin
                rdata[SOC_DW-1:0] = st_r.prog_i;
            end
            // figures of the model; the current maximum follows the selected scale
            SOC_OFS_ISET_MAX: begin
                rdata[SOC_DW-1:0] = imax_eff;
            end
            SOC_OFS_ISET_MIN: begin
                rdata[SOC_DW-1:0] = SOC_ZERO;
            end
            // limit and protection level as last accepted
            SOC_OFS_ILIM: begin
                rdata[SOC_DW-1:0] = st_r.ilim;
            end
            SOC_OFS_IPROT: begin
                rdata[SOC_DW-1:0] = st_r.iprot;
            end
            SOC_OFS_IPROT_MAX: begin
                rdata[SOC_DW-1:0] = IPROT_MAX;
            end
            SOC_OFS_IPROT_MIN: begin
                rdata[SOC_DW-1:0] = SOC_ZERO;
            end
            // range as a single bit, 1 for the high scale
            SOC_OFS_IRANGE: begin
                rdata[0] = st_r.range_hi;
            end
            // pending trigger value
            SOC_OFS_ITRIG: begin
                rdata[SOC_DW-1:0] = st_r.itrig;
            end
            // command words read as zero; the mode word reads 1 while the list runs
            SOC_OFS_TRIG_CMD: begin
                rdata = 32'h0000_0000;
            end
            SOC_OFS_MODE: begin
                rdata[0] = (st_r.mode == SOC_LIST);
            end
            SOC_OFS_LIST_CMD: begin
                rdata = 32'h0000_0000;
            end
            // error entry and breaker status words
            SOC_OFS_ERR: begin
                rdata[SOC_BIT_ERR_VALID] = st_r.err_valid;
                rdata[15:0] = st_r.err_code;
            end
            SOC_OFS_STATUS: begin
                rdata[SOC_BIT_STAT_TRIP] = st_r.trip;
            end
            // unmapped offset
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        // defaults: hold every field, no error event this cycle
        st_nxt = st_r;
        err_set = 1'b0;
        err_new = SOC_ERR_RANGE;
        err_clr = 1'b0;

        // apb answer: pready pulses in the second access cycle
        // pready is forced low the cycle after it rises, so back-to-back
        // transfers each see exactly one pulse
        st_nxt.rsp.pready = acc & ~st_r.rsp.pready;
        st_nxt.rsp.prdata = (acc & ~st_r.rsp.pready) ? rdata : 32'h0000_0000;
        st_nxt.rsp.pslverr = acc & ~st_r.rsp.pready & ~hit;

        // reading the error register consumes the entry
        // the clear acts at the completing edge, after the word was taken,
        // so the entry that was read is the one removed
        if (rd_done && apb_req.paddr == SOC_OFS_ERR) begin
            err_clr = 1'b1;
        end

        // list sequencer steps and completion
        // steps count only while the list runs; the step word may hold
        // anything in between. a finished list keeps its last step
        if (st_r.mode == SOC_LIST) begin
            if (list_step.valid) begin
                st_nxt.prog_v = list_step.vset;
                st_nxt.prog_i = list_step.iset;
            end
            if (list_step.done) begin
                st_nxt.mode = SOC_FIXED; // last step stays
            end
        end

        // register writes take effect at the completing edge
        // an out-of-range value completes the transfer normally; the stored
        // value stays and only the error entry records the refusal
        if (wr) begin
            case (apb_req.paddr)
                // enable bit: 0 turns the output off, 1 turns it on
                SOC_OFS_OUT_CTRL: begin
                    st_nxt.out_en = apb_req.pwdata[0];
                end
                // writes while disabled land in the saved copy
                // and apply at the next enable
                SOC_OFS_VSET: begin
                    st_nxt.prog_v = wval;
                end
                // the setpoint is bounded by the present limit
                SOC_OFS_ISET: begin
                    if (wval > st_r.ilim) begin
                        err_set = 1'b1;
                    end else begin
                        st_nxt.prog_i = wval;
                    end
                end
                // the limit may not exceed the protection level in force
                SOC_OFS_ILIM: begin
                    if (wval > st_r.iprot) begin
                        err_set = 1'b1;
                    end else begin
                        st_nxt.ilim = wval;
                    end
                end
                // the protection level is bounded by the factory maximum
                SOC_OFS_IPROT: begin
                    if (wval > IPROT_MAX) begin
                        err_set = 1'b1;
                    end else begin
                        st_nxt.iprot = wval;
                    end
                end
                // a range change turns the output off and leaves it off;
                // the host enables it again on the new scale
                SOC_OFS_IRANGE: begin
                    st_nxt.out_en = 1'b0;
                    st_nxt.range_hi = apb_req.pwdata[0];
                end
                // the pending trigger value is bounded by the present limit
                SOC_OFS_ITRIG: begin
                    if (wval > st_r.ilim) begin
                        err_set = 1'b1;
                    end else begin
                        st_nxt.itrig = wval;
                    end
                end
                // the trigger copies the pending value with no new
                // limit check: a value left above a lowered limit
                // still reaches the output
                SOC_OFS_TRIG_CMD: begin
                    st_nxt.prog_i = st_r.itrig;
                end
                // entering the list saves the setpoints for a stop;
                // writing the mode already in force changes nothing
                SOC_OFS_MODE: begin
                    if (apb_req.pwdata[0] && st_r.mode == SOC_FIXED) begin
                        st_nxt.pre_v = st_r.prog_v;
                        st_nxt.pre_i = st_r.prog_i;
                        st_nxt.mode = SOC_LIST;
                    end else if (!apb_req.pwdata[0] &&
                                 st_r.mode == SOC_LIST) begin
                        st_nxt.prog_v = st_r.pre_v;
                        st_nxt.prog_i = st_r.pre_i;
                        st_nxt.mode = SOC_FIXED;
                    end
                end
                // list setup is a no-op in fixed mode and a
                // command error while the list runs
                SOC_OFS_LIST_CMD: begin
                    if (st_r.mode == SOC_LIST) begin
                        err_set = 1'b1;
                        err_new = SOC_ERR_CMD;
                    end
                end
                // writing one to the trip bit clears it
                SOC_OFS_STATUS: begin
                    if (apb_req.pwdata[SOC_BIT_STAT_TRIP]) begin
                        st_nxt.trip = 1'b0;
                    end
                end
                // read-only and unmapped offsets change nothing
                default: begin
                    st_nxt.trip = st_r.trip;
                end
            endcase
        end

        // error entry: a new error wins over a same-cycle clear
        // the entry is one deep: a later error overwrites the code of an
        // earlier one that was never read
        if (err_set) begin
            st_nxt.err_valid = 1'b1;
            st_nxt.err_code = err_new;
        end else if (err_clr) begin
            st_nxt.err_valid = 1'b0;
        end

        // breaker: trip wins over clear
        // the trip only flags the event; it does not turn the output off
        // the compare uses the stored level, so a new protection value
        // acts from the edge after the write that stores it
        if (i_meas > st_r.iprot) begin
            st_nxt.trip = 1'b1;
        end

        // applied setpoints: saved values held, zero while disabled
        // the dac words follow the next-state enable, so the output
        // and its setpoints change at one edge; the programmed values
        // stay as the saved copy while disabled
        if (st_nxt.out_en) begin
            st_nxt.dac_v = st_nxt.prog_v;
            st_nxt.dac_i = st_nxt.prog_i;
        end else begin
            st_nxt.dac_v = SOC_ZERO;
            st_nxt.dac_i = SOC_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // synchronous reset: output enabled, setpoints zero, full model
    // figures as limit and protection level, no error pending
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_r.rsp <= '0;
            st_r.out_en <= 1'b1;
            st_r.range_hi <= 1'b1;
            st_r.mode <= SOC_FIXED;
            st_r.prog_v <= SOC_ZERO;
            st_r.prog_i <= SOC_ZERO;
            st_r.pre_v <= SOC_ZERO;
            st_r.pre_i <= SOC_ZERO;
            st_r.ilim <= IMAX;
            st_r.iprot <= IPROT_MAX;
            st_r.itrig <= SOC_ZERO;
            st_r.dac_v <= SOC_ZERO;
            st_r.dac_i <= SOC_ZERO;
            st_r.err_valid <= 1'b0;
            st_r.err_code <= 16'h0000;
            st_r.trip <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    // no output has a combinational path from an input; list_run is the
    // single mode bit of the state
    assign apb_rsp = st_r.rsp;
    assign list_run = (st_r.mode == SOC_LIST);
    assign out_en = st_r.out_en;
    assign range_hi = st_r.range_hi;
    assign dac_v = st_r.dac_v;
    assign dac_i = st_r.dac_i;
    assign breaker_trip = st_r.trip;

endmodule : soc_cmd

// >>> verification/soc_cmd_props.sv
// soc_cmd_props: port-level checks of the output/current command block
// assumes: bound into soc_cmd, one clock mclk, srst sync active high
`timescale 1ns/1ps
module soc_cmd_chk
    import soc_pkg::*;
#(
    parameter logic [SOC_DW-1:0] IMAX = SOC_IMAX_DEF,
    parameter logic [SOC_DW-1:0] IPROT_MAX = SOC_IPROT_MAX_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // apb
    input wire soc_apb_req_s apb_req,
    input wire soc_apb_rsp_s apb_rsp,
    // list and monitor
    input wire soc_step_s list_step,
    input wire logic list_run,
    input wire logic [SOC_DW-1:0] i_meas,
    // supply outputs
    input wire logic out_en,
    input wire logic range_hi,
    input wire logic [SOC_DW-1:0] dac_v,
    input wire logic [SOC_DW-1:0] dac_i,
    input wire logic breaker_trip
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic wr;
    logic [7:0] a;
    // committing write edge and its address
    assign wr = apb_rsp.pready && apb_req.psel && apb_req.penable
        && apb_req.pwrite;
    assign a = apb_req.paddr;
    ////////////////////////////////////////////////////////////////////
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_ack;
        !apb_rsp.pready ##1 apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence
    AST_APB_ACK: assert property (s_setup |=> s_ack)
        else $error("apb answer not in second access cycle");
    AST_RESET_VALS: assert property ($past(srst) |-> out_en && range_hi
        && !list_run && !breaker_trip && dac_v == 16'h0000)
        else $error("state after reset wrong");
    AST_OUT_SET: assert property (wr && a == SOC_OFS_OUT_CTRL |=>
        out_en == $past(apb_req.pwdata[0]))
        else $error("output enable not taken");
    AST_OFF_ZERO: assert property (!out_en |->
        dac_v == 16'h0000 && dac_i == 16'h0000)
        else $error("setpoints applied while disabled");
    AST_RANGE_OFF: assert property (wr && a == SOC_OFS_IRANGE |=> !out_en)
        else $error("range change left output on");
    AST_LIST_GO: assert property (wr && a == SOC_OFS_MODE
        && apb_req.pwdata[0] |=> list_run)
        else $error("list did not start");
    AST_LIST_FIX: assert property (wr && a == SOC_OFS_MODE
        && !apb_req.pwdata[0] |=> !list_run)
        else $error("list did not stop");
    AST_LIST_DONE: assert property (list_run && list_step.done |=> !list_run)
        else $error("list kept running after done");
    AST_TRIP_HOLD: assert property (breaker_trip
        && !(wr && a == SOC_OFS_STATUS) |=> breaker_trip)
        else $error("breaker trip dropped by itself");
endmodule : soc_cmd_chk

bind soc_cmd soc_cmd_chk #(.IMAX(IMAX), .IPROT_MAX(IPROT_MAX)) chk_u (
    .mclk, .srst, .apb_req, .apb_rsp, .list_step, .list_run, .i_meas,
    .out_en, .range_hi, .dac_v, .dac_i, .breaker_trip);

// >>> verification/soc_list_model.sv
// soc_list_model: list sequencer beside the command block
// assumes: steps sampled by the block on mclk while list_run is high
`timescale 1ns/1ps
module soc_list_model
    import soc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // block side
    input wire logic list_run,
    output soc_step_s list_step,
    // bench control: allow the list to finish on its own
    input wire logic fin_en
);
    logic [3:0] cnt_r;
    // step timer, restarts whenever the list is idle
    always_ff @(posedge mclk) begin
        if (srst || !list_run) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'hf) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // steps at counts 2 and 4, done at 6; junk that moves in between
    always_comb begin
        list_step.valid = list_run && (cnt_r == 4'h2 || cnt_r == 4'h4);
        list_step.done = list_run && fin_en && cnt_r == 4'h6;
        list_step.vset = list_step.valid ? {12'h010, cnt_r} : {4{cnt_r}};
        list_step.iset = list_step.valid ? {12'h040, cnt_r} : ~{4{cnt_r}};
    end
endmodule : soc_list_model

// >>> verification/tb_top.sv
// tb_top: register-level tests of the command block over apb
// assumes: soc_cmd with shortened model figures, list model partner
`timescale 1ns/1ps
module tb_top;
    import soc_pkg::*;
    localparam logic [SOC_DW-1:0] IMX = 16'h0fa0;
    localparam logic [SOC_DW-1:0] PMX = 16'h1388;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic fin_en = 1'b0;
    logic [SOC_DW-1:0] i_meas = 16'h0000;
    soc_apb_req_s req = '0;
    soc_apb_rsp_s rsp;
    soc_step_s step;
    logic list_run, out_en, range_hi, trip, e;
    logic [SOC_DW-1:0] dac_v, dac_i;
    logic [31:0] d;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
`define CHK(n, ex, got) begin compares++; if ((got) !== (ex)) begin \
    mismatches++; $display("unexpected %s exp %h got %h", n, ex, got); \
    end end
    soc_cmd #(.IMAX(IMX), .IPROT_MAX(PMX)) dut_u (
        .mclk(mclk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .list_step(step), .list_run(list_run), .i_meas(i_meas),
        .out_en(out_en), .range_hi(range_hi), .dac_v(dac_v),
        .dac_i(dac_i), .breaker_trip(trip));
    soc_list_model lm_u (.mclk(mclk), .srst(srst), .list_run(list_run),
        .list_step(step), .fin_en(fin_en));
    // clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // one apb transfer, held until pready is seen at an edge
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] wd);
        int n = 0;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= wd;
        req.psel <= 1'b1;
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        d = rsp.prdata;
        e = rsp.pslverr;
        if (n >= 20) mismatches++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(a, 1'b1, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        xfer(a, 1'b0, 32'h0);
        `CHK($sformatf("reg %h", a), ex, d)
    endtask : rd
    // error entry: code 0 means none pending
    task automatic ec(input logic [15:0] c);
        xfer(SOC_OFS_ERR, 1'b0, 32'h0);
        if (c == 16'h0000) `CHK("err flag", 1'b0, d[16])
        else `CHK("err", {15'h0000, 1'b1, c}, d)
    endtask : ec
    ////////////////////////////////////////////////////////////////////
    logic [7:0] ra [10] = '{SOC_OFS_OUT_CTRL, SOC_OFS_MODE, SOC_OFS_IRANGE,
        SOC_OFS_ILIM, SOC_OFS_IPROT, SOC_OFS_IPROT_MAX, SOC_OFS_IPROT_MIN,
        SOC_OFS_ISET_MAX, SOC_OFS_ISET_MIN, SOC_OFS_ITRIG};
    logic [15:0] rv [10] = '{16'h0001, 16'h0000, 16'h0001, IMX, PMX, PMX,
        16'h0000, IMX, 16'h0000, 16'h0000};
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 10; k++) rd(ra[k], {16'h0, rv[k]});
        xfer(8'h40, 1'b0, 32'h0);
        `CHK("slverr", 1'b1, e)
        wr(SOC_OFS_VSET, 32'h0100);
        wr(SOC_OFS_ISET, 32'h0200);
        wr(SOC_OFS_OUT_CTRL, 32'h0);
        `CHK("dac_v", 16'h0000, dac_v)
        rd(SOC_OFS_ISET, 32'h0200);
        rd(SOC_OFS_VSET, 32'h0100);
        rd(SOC_OFS_OUT_CTRL, 32'h0);
        wr(SOC_OFS_ISET, 32'h0300);
        wr(SOC_OFS_OUT_CTRL, 32'h1);
        `CHK("dac_i", 16'h0300, dac_i)
        `CHK("dac_v", 16'h0100, dac_v)
        wr(SOC_OFS_ILIM, 32'h0800);
        rd(SOC_OFS_ILIM, 32'h0800);
        wr(SOC_OFS_ISET, 32'h0900);
        ec(16'hff22);
        rd(SOC_OFS_ISET, 32'h0300);
        wr(SOC_OFS_ILIM, 32'h2000);
        ec(16'hff22);
        rd(SOC_OFS_ILIM, 32'h0800);
        wr(SOC_OFS_ITRIG, 32'h0900);
        ec(16'hff22);
        rd(SOC_OFS_ITRIG, 32'h0);
        wr(SOC_OFS_ITRIG, 32'h0700);
        ec(16'h0000);
        rd(SOC_OFS_ITRIG, 32'h0700);
        wr(SOC_OFS_TRIG_CMD, 32'h0);
        `CHK("dac_i", 16'h0700, dac_i)
        wr(SOC_OFS_ILIM, 32'h0500);
        wr(SOC_OFS_ITRIG, 32'h0400);
        ec(16'h0000);
        rd(SOC_OFS_ITRIG, 32'h0400);
        wr(SOC_OFS_IPROT, 32'h2000);
        ec(16'hff22);
        wr(SOC_OFS_IPROT, 32'h0600);
        rd(SOC_OFS_IPROT, 32'h0600);
        i_meas <= 16'h0600;
        repeat (2) @(posedge mclk);
        `CHK("trip", 1'b0, trip)
        i_meas <= 16'h0601;
        repeat (2) @(posedge mclk);
        `CHK("trip", 1'b1, trip)
        i_meas <= 16'h0000;
        wr(SOC_OFS_STATUS, 32'h1);
        rd(SOC_OFS_STATUS, 32'h0);
        wr(SOC_OFS_IRANGE, 32'h0);
        `CHK("out_en", 1'b0, out_en)
        `CHK("range_hi", 1'b0, range_hi)
        rd(SOC_OFS_IRANGE, 32'h0);
        rd(SOC_OFS_ISET_MAX, {16'h0, IMX / SOC_RANGE_DIV});
        wr(SOC_OFS_IRANGE, 32'h1);
        rd(SOC_OFS_IRANGE, 32'h1);
        wr(SOC_OFS_OUT_CTRL, 32'h1);
        wr(SOC_OFS_MODE, 32'h1);
        rd(SOC_OFS_MODE, 32'h1);
        wr(SOC_OFS_LIST_CMD, 32'h0);
        ec(16'hff9c);
        rd(SOC_OFS_ISET, 32'h0404);
        rd(SOC_OFS_VSET, 32'h0104);
        wr(SOC_OFS_MODE, 32'h0);
        rd(SOC_OFS_ISET, 32'h0700);
        rd(SOC_OFS_VSET, 32'h0100);
        rd(SOC_OFS_MODE, 32'h0);
        wr(SOC_OFS_LIST_CMD, 32'h0);
        ec(16'h0000);
        fin_en <= 1'b1;
        wr(SOC_OFS_MODE, 32'h1);
        repeat (20) if (list_run === 1'b1) @(posedge mclk);
        `CHK("list_run", 1'b0, list_run)
        rd(SOC_OFS_ISET, 32'h0404);
        rd(SOC_OFS_VSET, 32'h0104);
        rd(SOC_OFS_MODE, 32'h0);
        finish_test();
    end
endmodule : tb_top
